// File: shared/eeps_pkg.sv
// constants and types shared by the eeprom erase and protect sequencer
package eeps_pkg;

	// bus geometry
	localparam int unsigned AXI_ADDR_W      = 18;
	localparam int unsigned AXI_DATA_W      = 32;
	localparam int unsigned IDX_W           = 16;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_ARRAY_LO    = 16'h0800;
	localparam logic [15:0] IDX_ARRAY_HI    = 16'h09FF;
	localparam logic [15:0] IDX_NV_CONFIG   = 16'hFE1C;
	localparam logic [15:0] IDX_CONTROL     = 16'hFE1D;
	localparam logic [15:0] IDX_ACT_CONFIG  = 16'hFE1F;
	localparam logic [15:0] IDX_HV_TIME     = 16'hFE20;
	localparam logic [15:0] IDX_STATUS      = 16'hFE21;

	// array geometry
	localparam int unsigned ARRAY_BYTES     = 512;
	localparam int unsigned ARRAY_AW        = 9;
	localparam int unsigned HALF_BIT        = 8;
	localparam int unsigned BLOCK_LSB       = 7;

	// control register fields
	localparam int unsigned CTL_PUMP_CLK    = 7;
	localparam int unsigned CTL_POWER_DOWN  = 5;
	localparam int unsigned CTL_MODE_HI     = 4;
	localparam int unsigned CTL_MODE_LO     = 3;
	localparam int unsigned CTL_LATCH       = 1;
	localparam int unsigned CTL_HV_ENABLE   = 0;
	localparam logic [7:0]  CTL_RESET       = 8'h00;

	// configuration byte fields
	localparam int unsigned CFG_REDUNDANT   = 7;
	localparam int unsigned CFG_PROT_LSB    = 0;
	localparam int unsigned CFG_PROT_W      = 4;
	localparam logic [7:0]  CFG_WMASK       = 8'h8F;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam logic [7:0]  ACR_RESET       = 8'h00;

	// status register fields
	localparam int unsigned STA_NONARRAY_WR = 0;
	localparam int unsigned STA_TARGET_OK   = 1;
	localparam int unsigned STA_HV_ON       = 2;
	localparam int unsigned STA_OP_DONE     = 3;

	// high-voltage dwell in bus-clock cycles, software may rewrite it
	localparam logic [31:0] HV_CYCLES_RESET = 32'h0000_0FA0;

	// axi responses
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;

	typedef enum logic [1:0] {
		EEPS_BYTE_PROGRAM,
		EEPS_BYTE_ERASE,
		EEPS_BLOCK_ERASE,
		EEPS_BULK_ERASE
	} eeps_mode_t;

	typedef enum logic [2:0] {
		EEPS_REG_ARRAY,
		EEPS_REG_NV,
		EEPS_REG_CONTROL,
		EEPS_REG_ACT,
		EEPS_REG_HV_TIME,
		EEPS_REG_STATUS,
		EEPS_REG_NONE
	} eeps_region_t;

endpackage : eeps_pkg

// File: hw/eeps_hv_timer.sv
// high-voltage dwell counter for the eeprom sequencer
`timescale 1ns/1ns
module eeps_hv_timer (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        run_i,
	input  wire logic        clear_i,
	input  wire logic [31:0] limit_i,
	output logic             done_o
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        done;
	} eeps_tmr_st_t;

	eeps_tmr_st_t st_q;
	eeps_tmr_st_t st_d;

	// counts only while voltage is on, so a stop-mode pause does not count as dwell
	always_comb begin
		st_d = st_q;
		if (clear_i) begin
			st_d.cnt  = 32'h0000_0000;
			st_d.done = 1'b0;
		end else if (run_i && !st_q.done) begin
			st_d.cnt = st_q.cnt + 32'h0000_0001;
			if (st_d.cnt >= limit_i) begin
				st_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done_o = st_q.done;

endmodule : eeps_hv_timer

// File: hw/eeps_sequencer.sv
// eeprom erase, program and block protect sequencer with axi4-lite registers
`timescale 1ns/1ns
// How it works
// - redundant erase of lower half hits mirror
// - only unprotected array bytes and config erase
// - mode field picks operation; protect blocks it
// - latch captures only valid array and config writes, newest
// - block erase clears whole addressed block
// - bulk erases all; config byte untouched
// - latched reads return data; control opens afterwards
// - no enable after non-array write, latch clear
// - mode frozen while enable is set
// - voltage only with latch and valid write
// - clearing both clears only enable
// - four blocks; protected block gets no voltage
// - protect ranges ascending; any effective protect kills bulk
// - redundant: lower doubles, upper ignored, upper protects moot
// - active config reloads at reset and config read
// - config layout: redundant bit7, protects 3..0
// - pump clock select; reset clears control
// - power down makes array reads return erased
// - wait mode leaves operation running
// - stop drops voltage, keeps enable, restores after
// - erased is ones; program only clears bits
module eeps_sequencer (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic [17:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [17:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        stop_mode_i,
	output logic             hv_on_o,
	output logic             pump_clock_select_o,
	output logic             array_power_down_o
);

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  acr;
		logic        reload;
		logic        target_ok;
		logic        nonarray_wr;
		logic        target_nv;
		logic [8:0]  target;
		logic [7:0]  data;
		logic        hv_on;
		logic        op_done;
		logic [31:0] hv_cycles;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} eeps_seq_st_t;

	eeps_seq_st_t st_q;
	eeps_seq_st_t st_d;

	logic [7:0]               array_q [eeps_pkg::ARRAY_BYTES];
	logic [7:0]               nv_config_q;
	logic                     timer_done;
	logic                     commit;
	logic                     wr_go;
	logic                     rd_go;
	logic                     allowed;
	logic                     redundant;
	logic [3:0]               prot_eff;
	logic [7:0]               array_rd;
	eeps_pkg::eeps_mode_t     mode;
	eeps_pkg::eeps_region_t   wr_region;
	eeps_pkg::eeps_region_t   rd_region;

	function automatic eeps_pkg::eeps_region_t decode(input logic [17:0] addr);
		logic [15:0] idx;
		idx = addr[17:2];
		if (idx >= eeps_pkg::IDX_ARRAY_LO && idx <= eeps_pkg::IDX_ARRAY_HI) begin
			decode = eeps_pkg::EEPS_REG_ARRAY;
		end else if (idx == eeps_pkg::IDX_NV_CONFIG) begin
			decode = eeps_pkg::EEPS_REG_NV;
		end else if (idx == eeps_pkg::IDX_CONTROL) begin
			decode = eeps_pkg::EEPS_REG_CONTROL;
		end else if (idx == eeps_pkg::IDX_ACT_CONFIG) begin
			decode = eeps_pkg::EEPS_REG_ACT;
		end else if (idx == eeps_pkg::IDX_HV_TIME) begin
			decode = eeps_pkg::EEPS_REG_HV_TIME;
		end else if (idx == eeps_pkg::IDX_STATUS) begin
			decode = eeps_pkg::EEPS_REG_STATUS;
		end else begin
			decode = eeps_pkg::EEPS_REG_NONE;
		end
	endfunction : decode

	// which physical bytes one committed operation touches
	function automatic logic hits(input logic [8:0] i, input logic [8:0] tgt,
	                              input eeps_pkg::eeps_mode_t m, input logic red);
		unique case (m)
			eeps_pkg::EEPS_BYTE_PROGRAM,
			eeps_pkg::EEPS_BYTE_ERASE: begin
				hits = (i == tgt) || (red && i == {1'b1, tgt[7:0]});
			end
			eeps_pkg::EEPS_BLOCK_ERASE: begin
				hits = (i[8:7] == tgt[8:7]) || (red && i[7] == tgt[7]);
			end
			eeps_pkg::EEPS_BULK_ERASE: begin
				hits = 1'b1;
			end
		endcase
	endfunction : hits

	assign mode      = eeps_pkg::eeps_mode_t'({st_q.ctrl[eeps_pkg::CTL_MODE_HI], st_q.ctrl[eeps_pkg::CTL_MODE_LO]});
	assign redundant = st_q.acr[eeps_pkg::CFG_REDUNDANT];
	assign prot_eff  = redundant ? {2'b00, st_q.acr[1:0]} : st_q.acr[3:0];
	assign wr_go     = s_axi_awvalid_i && s_axi_wvalid_i && !st_q.bvalid;
	assign rd_go     = s_axi_arvalid_i && !st_q.rvalid;
	assign wr_region = decode(s_axi_awaddr_i);
	assign rd_region = decode(s_axi_araddr_i);
	assign commit    = st_q.hv_on && timer_done && !st_q.op_done;

	// whether the latched target may receive voltage at all
	always_comb begin
		if (st_q.target_nv) begin
			allowed = (mode == eeps_pkg::EEPS_BYTE_PROGRAM) || (mode == eeps_pkg::EEPS_BYTE_ERASE);
		end else if (redundant && st_q.target[eeps_pkg::HALF_BIT]) begin
			allowed = 1'b0;
		end else if (mode == eeps_pkg::EEPS_BULK_ERASE) begin
			allowed = (prot_eff == 4'h0);
		end else begin
			allowed = !prot_eff[st_q.target[8:7]];
		end
	end

	// powered-down array reads back as erased; latched reads return the latched byte
	always_comb begin
		logic [8:0] idx;
		idx = s_axi_araddr_i[10:2];
		if (st_q.ctrl[eeps_pkg::CTL_POWER_DOWN]) begin
			array_rd = eeps_pkg::ERASED_BYTE;
		end else if (st_q.ctrl[eeps_pkg::CTL_LATCH]) begin
			array_rd = st_q.data;
		end else if (redundant && idx[eeps_pkg::HALF_BIT]) begin
			array_rd = eeps_pkg::ERASED_BYTE;
		end else begin
			array_rd = array_q[idx];
		end
	end

	always_comb begin
		logic [7:0] wb;
		logic [7:0] c;
		logic       hv_en;
		logic       latch;
		logic       may_set;
		wb      = s_axi_wdata_i[7:0];
		hv_en   = st_q.ctrl[eeps_pkg::CTL_HV_ENABLE];
		latch   = st_q.ctrl[eeps_pkg::CTL_LATCH];
		may_set = !(!latch && st_q.nonarray_wr) && !(latch && !st_q.target_ok);
		c       = st_q.ctrl;
		st_d    = st_q;
		if (st_q.bvalid && s_axi_bready_i) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.rvalid && s_axi_rready_i) begin
			st_d.rvalid = 1'b0;
		end
		if (st_q.reload) begin
			st_d.acr    = nv_config_q & eeps_pkg::CFG_WMASK;
			st_d.reload = 1'b0;
		end
		if (wr_go) begin
			st_d.bvalid = 1'b1;
			st_d.bresp  = (wr_region == eeps_pkg::EEPS_REG_NONE) ? eeps_pkg::RESP_SLVERR : eeps_pkg::RESP_OKAY;
			if (s_axi_wstrb_i[0]) begin
				unique case (wr_region)
					eeps_pkg::EEPS_REG_ARRAY,
					eeps_pkg::EEPS_REG_NV: begin
						// target is frozen once voltage may be on
						if (latch && !hv_en) begin
							st_d.target_nv   = (wr_region == eeps_pkg::EEPS_REG_NV);
							st_d.target      = s_axi_awaddr_i[10:2];
							st_d.data        = wb;
							st_d.target_ok   = 1'b1;
							st_d.nonarray_wr = 1'b0;
						end
					end
					eeps_pkg::EEPS_REG_CONTROL: begin
						c[eeps_pkg::CTL_PUMP_CLK]   = wb[eeps_pkg::CTL_PUMP_CLK];
						c[eeps_pkg::CTL_POWER_DOWN] = wb[eeps_pkg::CTL_POWER_DOWN];
						if (!hv_en) begin
							c[eeps_pkg::CTL_MODE_HI] = wb[eeps_pkg::CTL_MODE_HI];
							c[eeps_pkg::CTL_MODE_LO] = wb[eeps_pkg::CTL_MODE_LO];
						end
						c[eeps_pkg::CTL_LATCH] = hv_en ? 1'b1 : wb[eeps_pkg::CTL_LATCH];
						c[eeps_pkg::CTL_HV_ENABLE] = wb[eeps_pkg::CTL_HV_ENABLE] && (hv_en || may_set);
						if (!c[eeps_pkg::CTL_LATCH]) begin
							st_d.target_ok = 1'b0;
						end
						st_d.ctrl = c;
					end
					eeps_pkg::EEPS_REG_HV_TIME: begin
						st_d.hv_cycles   = s_axi_wdata_i;
						st_d.nonarray_wr = 1'b1;
					end
					default: begin
						st_d.nonarray_wr = 1'b1;
					end
				endcase
			end else if (wr_region != eeps_pkg::EEPS_REG_ARRAY && wr_region != eeps_pkg::EEPS_REG_NV
			             && wr_region != eeps_pkg::EEPS_REG_CONTROL) begin
				st_d.nonarray_wr = 1'b1;
			end
		end
		if (rd_go) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = eeps_pkg::RESP_OKAY;
			st_d.rdata  = 32'h0000_0000;
			unique case (rd_region)
				eeps_pkg::EEPS_REG_ARRAY: begin
					st_d.rdata[7:0] = array_rd;
				end
				eeps_pkg::EEPS_REG_NV: begin
					st_d.rdata[7:0] = nv_config_q & eeps_pkg::CFG_WMASK;
					st_d.acr        = nv_config_q & eeps_pkg::CFG_WMASK;
				end
				eeps_pkg::EEPS_REG_CONTROL: begin
					st_d.rdata[7:0] = st_q.ctrl;
				end
				eeps_pkg::EEPS_REG_ACT: begin
					st_d.rdata[7:0] = st_q.acr;
				end
				eeps_pkg::EEPS_REG_HV_TIME: begin
					st_d.rdata = st_q.hv_cycles;
				end
				eeps_pkg::EEPS_REG_STATUS: begin
					st_d.rdata[eeps_pkg::STA_NONARRAY_WR] = st_q.nonarray_wr;
					st_d.rdata[eeps_pkg::STA_TARGET_OK]   = st_q.target_ok;
					st_d.rdata[eeps_pkg::STA_HV_ON]       = st_q.hv_on;
					st_d.rdata[eeps_pkg::STA_OP_DONE]     = st_q.op_done;
				end
				default: begin
					st_d.rresp = eeps_pkg::RESP_SLVERR;
				end
			endcase
		end
		// wait mode has no path into this term, so an operation simply carries on
		st_d.hv_on = st_q.ctrl[eeps_pkg::CTL_HV_ENABLE] && st_q.ctrl[eeps_pkg::CTL_LATCH]
		             && st_q.target_ok && allowed && !stop_mode_i;
		// a commit in the cycle the enable drops must still be reported
		if (commit) begin
			st_d.op_done = 1'b1;
		end else if (!st_q.ctrl[eeps_pkg::CTL_HV_ENABLE]) begin
			st_d.op_done = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q           <= '0;
			st_q.ctrl      <= eeps_pkg::CTL_RESET;
			st_q.acr       <= eeps_pkg::ACR_RESET;
			st_q.reload    <= 1'b1;
			st_q.hv_cycles <= eeps_pkg::HV_CYCLES_RESET;
			st_q.bresp     <= eeps_pkg::RESP_OKAY;
			st_q.rresp     <= eeps_pkg::RESP_OKAY;
		end else begin
			st_q <= st_d;
		end
	end

	eeps_hv_timer u_hv_timer (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.run_i     (st_q.hv_on),
		.clear_i   (!st_q.ctrl[eeps_pkg::CTL_HV_ENABLE]),
		.limit_i   (st_q.hv_cycles),
		.done_o    (timer_done)
	);

	// cell array; a program can only pull bits low, an erase returns them high
	for (genvar g = 0; g < eeps_pkg::ARRAY_BYTES; g++) begin : g_cell
		always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				array_q[g] <= eeps_pkg::ERASED_BYTE;
			end else if (commit && !st_q.target_nv && hits(9'(g), st_q.target, mode, redundant)) begin
				if (mode == eeps_pkg::EEPS_BYTE_PROGRAM) begin
					array_q[g] <= array_q[g] & st_q.data;
				end else begin
					array_q[g] <= eeps_pkg::ERASED_BYTE;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nv_config_q <= eeps_pkg::ERASED_BYTE;
		end else if (commit && st_q.target_nv) begin
			if (mode == eeps_pkg::EEPS_BYTE_PROGRAM) begin
				nv_config_q <= nv_config_q & st_q.data;
			end else begin
				nv_config_q <= eeps_pkg::ERASED_BYTE;
			end
		end
	end

	assign s_axi_awready_o     = wr_go;
	assign s_axi_wready_o      = wr_go;
	assign s_axi_bvalid_o      = st_q.bvalid;
	assign s_axi_bresp_o       = st_q.bresp;
	assign s_axi_arready_o     = !st_q.rvalid;
	assign s_axi_rvalid_o      = st_q.rvalid;
	assign s_axi_rdata_o       = st_q.rdata;
	assign s_axi_rresp_o       = st_q.rresp;
	assign hv_on_o             = st_q.hv_on;
	assign pump_clock_select_o = st_q.ctrl[eeps_pkg::CTL_PUMP_CLK];
	assign array_power_down_o  = st_q.ctrl[eeps_pkg::CTL_POWER_DOWN];

endmodule : eeps_sequencer

// File: verification/eeps_properties.sv
// timing checks on the sequencer ports
`timescale 1ns/1ns
module eeps_props (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic [17:0] s_axi_awaddr_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0]  s_axi_wstrb_i,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        stop_mode_i,
	input wire logic        hv_on_o,
	input wire logic        pump_clock_select_o,
	input wire logic        array_power_down_o
);
	logic wr_tk;
	logic ctl_wr;
	logic no_wr;
	assign wr_tk  = s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o;
	assign ctl_wr = wr_tk && s_axi_wstrb_i[0] && s_axi_awaddr_i[17:2] == eeps_pkg::IDX_CONTROL;
	assign no_wr  = !(s_axi_awvalid_i && s_axi_wvalid_i);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// no write may clear the enable meanwhile, else resume is not owed
	sequence s_hv_paused;
		hv_on_o && no_wr ##1 (stop_mode_i && no_wr) [*2];
	endsequence
	sequence s_stop_left;
		!stop_mode_i && no_wr;
	endsequence
	AST_WR_ANSWER: assert property (wr_tk |=> s_axi_bvalid_o)
		else $error("write not answered");
	AST_RD_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read not answered");
	AST_WR_BLOCKED: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
		else $error("write taken during response");
	AST_STOP_DROPS_HV: assert property (stop_mode_i |=> !hv_on_o)
		else $error("voltage on in stop");
	AST_HV_RESUME: assert property (s_hv_paused ##1 s_stop_left |=> hv_on_o)
		else $error("voltage not restored");
	AST_HV_CAUSE: assert property ($rose(hv_on_o) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(stop_mode_i, 2))
		else $error("voltage without enable");
	AST_CTL_PINS: assert property (!$stable({pump_clock_select_o, array_power_down_o}) |-> $past(ctl_wr))
		else $error("control pins moved alone");
	AST_HV_OFF: assert property (ctl_wr && !s_axi_wdata_i[0] |-> ##[1:2] !hv_on_o)
		else $error("voltage kept after disable");
endmodule : eeps_props
bind eeps_sequencer eeps_props u_props (.clk_sys_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rvalid_o, .stop_mode_i, .hv_on_o, .pump_clock_select_o, .array_power_down_o);

// File: verification/eeps_cpu_model.sv
// register bus master standing in for the cpu
`timescale 1ns/1ns
module eeps_cpu_model (
	input  wire logic        clk_sys_i,
	output logic [17:0]      awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [17:0]      araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o,
	output logic             tmo_o
);
	// ready and valid lines are sampled at the rising edge that takes the item
	initial begin
		{awvalid_o, wvalid_o, arvalid_o, tmo_o} = 4'h0;
		{awaddr_o, araddr_o, wdata_o} = 68'h0;
		wstrb_o = 4'hF;
		bready_o = 1'b1;
		rready_o = 1'b1;
	end
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] resp);
		int   n;
		logic aw_pend;
		logic w_pend;
		n = 0;
		aw_pend = 1'b1;
		w_pend = 1'b1;
		awaddr_o <= {idx, 2'b00};
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		while ((aw_pend || w_pend) && n < 200) begin
			@(posedge clk_sys_i);
			n++;
			if (aw_pend && awready_i === 1'b1) begin
				aw_pend = 1'b0;
				awvalid_o <= 1'b0;
			end
			if (w_pend && wready_i === 1'b1) begin
				w_pend = 1'b0;
				wvalid_o <= 1'b0;
			end
		end
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (bvalid_i !== 1'b1 && n < 200);
		resp = bresp_i;
		if (n >= 200) tmo_o <= 1'b1;
	endtask : wr
	task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		araddr_o <= {idx, 2'b00};
		arvalid_o <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (arready_i !== 1'b1 && n < 200);
		arvalid_o <= 1'b0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (rvalid_i !== 1'b1 && n < 200);
		d = rdata_i;
		resp = rresp_i;
		if (n >= 200) tmo_o <= 1'b1;
	endtask : rd
endmodule : eeps_cpu_model

// File: verification/tb_top.sv
// self-checking bench for the eeprom sequencer
`timescale 1ns/1ns
module tb_top;
	localparam logic [15:0] CTL = eeps_pkg::IDX_CONTROL;
	localparam logic [15:0] NV  = eeps_pkg::IDX_NV_CONFIG;
	localparam logic [15:0] ACT = eeps_pkg::IDX_ACT_CONFIG;
	localparam int          HV  = 4;
	logic        clk_sys_i, rst_b_i, stop_mode_i, tmo, hv_on_o, pump_clock_select_o, array_power_down_o;
	logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic [17:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	int          error_cnt = 0;
	int          cmp_count = 0;
	eeps_sequencer uut (.clk_sys_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .stop_mode_i, .hv_on_o, .pump_clock_select_o, .array_power_down_o);
	eeps_cpu_model cpu (.clk_sys_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
		.awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i),
		.wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i),
		.araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o),
		.rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i),
		.tmo_o(tmo));
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_val
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	always @(posedge tmo) begin
		error_cnt++;
		stop_test();
	end
	task automatic w8(input logic [15:0] i, input logic [7:0] d);
		logic [1:0] r;
		cpu.wr(i, {24'h000000, d}, r);
		cmp_val("bresp", 32'h0, {30'h0, r});
	endtask : w8
	task automatic chk(input logic [15:0] i, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		cpu.rd(i, d, r);
		cmp_val("rdata", {24'h000000, e}, d);
	endtask : chk
	// one full software step sequence; stp pauses it with stop mode
	task automatic op(input logic [1:0] m, input logic [15:0] idx, input logic [7:0] d, input logic hv, input logic stp);
		logic [7:0] c;
		c = {3'b000, m, 3'b010};
		w8(CTL, c);
		w8(idx, d);
		if (idx != NV) chk(idx ^ 16'h0001, d);
		w8(CTL, c | 8'h01);
		w8(CTL, (c ^ 8'h18) | 8'h01);
		chk(CTL, c | 8'h01);
		cmp_val("hv_on", {31'h0, hv}, {31'h0, hv_on_o});
		if (stp) begin
			stop_mode_i <= 1'b1;
			repeat (3) @(posedge clk_sys_i);
			cmp_val("hv_on stop", 32'h0, {31'h0, hv_on_o});
			stop_mode_i <= 1'b0;
			repeat (2) @(posedge clk_sys_i);
			cmp_val("hv_on resume", 32'h1, {31'h0, hv_on_o});
		end
		repeat (HV + 6) @(posedge clk_sys_i);
		w8(CTL, c & 8'h18);
		chk(CTL, c);
		w8(CTL, 8'h00);
	endtask : op
	task automatic t_start();
		logic [31:0] d;
		logic [1:0]  r;
		chk(CTL, 8'h00);
		chk(ACT, 8'h8F);
		cpu.rd(16'h0000, d, r);
		cmp_val("rresp", {30'h0, eeps_pkg::RESP_SLVERR}, {30'h0, r});
		w8(CTL, 8'hA0);
		cmp_val("pins", 32'h3, {30'h0, pump_clock_select_o, array_power_down_o});
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		cmp_val("pins", 32'h0, {30'h0, pump_clock_select_o, array_power_down_o});
		chk(CTL, 8'h00);
		$display("reset and pins done");
	endtask : t_start
	task automatic t_refuse();
		logic [1:0] r;
		w8(eeps_pkg::IDX_HV_TIME, 8'(HV));
		w8(CTL, 8'h01);
		chk(CTL, 8'h00);
		w8(CTL, 8'h02);
		cpu.wr(16'h0000, 32'h0, r);
		cmp_val("bresp", {30'h0, eeps_pkg::RESP_SLVERR}, {30'h0, r});
		w8(CTL, 8'h03);
		chk(CTL, 8'h02);
		cmp_val("hv_on", 32'h0, {31'h0, hv_on_o});
		w8(CTL, 8'h00);
		op(2'b00, eeps_pkg::IDX_ARRAY_LO, 8'h5A, 1'b0, 1'b0);
		op(2'b11, 16'h0880, 8'h00, 1'b0, 1'b0);
		chk(eeps_pkg::IDX_ARRAY_LO, 8'hFF);
		$display("refusals done");
	endtask : t_refuse
	task automatic t_ops();
		op(2'b00, NV, 8'h00, 1'b1, 1'b0);
		chk(ACT, 8'h8F);
		chk(NV, 8'h00);
		chk(ACT, 8'h00);
		op(2'b00, 16'h0801, 8'h5A, 1'b1, 1'b1);
		chk(16'h0801, 8'h5A);
		op(2'b00, 16'h0801, 8'hA5, 1'b1, 1'b0);
		chk(16'h0801, 8'h00);
		w8(CTL, 8'h20);
		chk(16'h0801, 8'hFF);
		w8(CTL, 8'h00);
		op(2'b01, 16'h0801, 8'h77, 1'b1, 1'b0);
		chk(16'h0801, 8'hFF);
		op(2'b00, 16'h0802, 8'h00, 1'b1, 1'b0);
		op(2'b00, 16'h0900, 8'h00, 1'b1, 1'b0);
		op(2'b10, 16'h0870, 8'h33, 1'b1, 1'b0);
		chk(16'h0802, 8'hFF);
		chk(16'h0900, 8'h00);
		op(2'b11, 16'h09FF, 8'h33, 1'b1, 1'b0);
		chk(16'h0900, 8'hFF);
		chk(NV, 8'h00);
		op(2'b01, NV, 8'h00, 1'b1, 1'b0);
		op(2'b00, NV, 8'h80, 1'b1, 1'b0);
		chk(NV, 8'h80);
		op(2'b00, 16'h0810, 8'h3C, 1'b1, 1'b0);
		chk(16'h0810, 8'h3C);
		op(2'b00, 16'h0910, 8'h00, 1'b0, 1'b0);
		chk(16'h0910, 8'hFF);
		op(2'b01, NV, 8'h00, 1'b1, 1'b0);
		op(2'b00, NV, 8'h00, 1'b1, 1'b0);
		chk(NV, 8'h00);
		chk(16'h0910, 8'h3C);
		$display("array operations done");
	endtask : t_ops
	initial begin
		rst_b_i = 1'b0;
		stop_mode_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		t_start();
		t_refuse();
		t_ops();
		stop_test();
	end
endmodule : tb_top
